// file: logic/status_irq_top.sv
`timescale 1ns/1ps
module status_irq_top (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic            int_n,
    input  wire logic       rx_pos_in,
    input  wire logic       rx_neg_in,
    input  wire logic       rx_bit_strobe,
    input  wire logic       resync_done,
    input  wire logic [7:0] frame_offset,
    input  wire logic       rx_estore_full,
    input  wire logic       rx_estore_empty,
    input  wire logic       fbit_strobe,
    input  wire logic       fbit_error,
    input  wire logic [7:0] stat_one_src,
    input  wire logic [7:0] stat_two_src,
    input  wire logic [7:0] info_two_src,
    input  wire logic [7:0] info_three_src,
    input  wire logic [7:0] hdlc_stat_src
);
    typedef struct packed {
        logic [2:0]                          rx_meta;
        logic [2:0]                          rx_sync;
        logic                                strobe_prev;
        logic [4:0]                          zero_count;
        logic [7:0]                          pos_hist;
        logic [7:0]                          neg_hist;
        logic [status_pkg::SEF_WINDOW-1:0]   fbit_hist;
        logic [7:0]                          last_offset;
        logic                                offset_known;
        logic [7:0]                          line_evt;
        logic [7:0]                          irq_mask_one;
        logic [7:0]                          irq_mask_two;
        logic [7:0]                          hdlc_irq_mask;
        logic [7:0]                          rd_data;
        logic                                int_n;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [status_pkg::NUM_FLAG-1:0][7:0] src_all;
    logic [status_pkg::NUM_FLAG-1:0][7:0] flags_all;
    logic [status_pkg::NUM_FLAG-1:0][7:0] pend_all;
    logic                                 bit_take;
    logic                                 pos_now;
    logic                                 neg_now;
    logic [7:0]                           pos_new;
    logic [7:0]                           neg_new;
    logic [status_pkg::SEF_WINDOW-1:0]    fbit_new;
    logic [7:0]                           rd_mux;
    logic [7:0]                           unmasked;

    assign src_all[status_pkg::STAT_ONE_IDX]   = stat_one_src;
    assign src_all[status_pkg::STAT_TWO_IDX]   = stat_two_src;
    assign src_all[status_pkg::INFO_ONE_IDX]   = st.line_evt;
    assign src_all[status_pkg::INFO_TWO_IDX]   = info_two_src;
    assign src_all[status_pkg::INFO_THREE_IDX] = info_three_src;
    assign src_all[status_pkg::HDLC_IDX]       = hdlc_stat_src;

    flag_bus_if fb[status_pkg::NUM_FLAG] ();

    for (genvar i = 0; i < status_pkg::NUM_FLAG; i++) begin : g_flag
        assign fb[i].wr    = wr_en && (addr == status_pkg::FLAG_ADDR[i]);
        assign fb[i].rd    = rd_en && (addr == status_pkg::FLAG_ADDR[i]);
        assign fb[i].wdata = wr_data;
        assign fb[i].src   = src_all[i];
        assign flags_all[i] = fb[i].flags;
        assign pend_all[i]  = fb[i].pend;
        flag_reg #(
            .alarm_bits (i == status_pkg::STAT_ONE_IDX ?
                         status_pkg::STAT_ONE_ALARMS :
                         status_pkg::NO_ALARM_BITS)
        ) u_flag (
            .clk  (clk),
            .srst (srst),
            .bus  (fb[i])
        );
    end

    always_comb begin
        next_st  = st;
        // Pin inputs pass two flip-flops
        next_st.rx_meta = {rx_bit_strobe, rx_pos_in, rx_neg_in};
        next_st.rx_sync = st.rx_meta;
        next_st.strobe_prev = st.rx_sync[status_pkg::RX_STB];
        bit_take = st.rx_sync[status_pkg::RX_STB] & ~st.strobe_prev;
        pos_now  = st.rx_sync[status_pkg::RX_POS];
        neg_now  = st.rx_sync[status_pkg::RX_NEG];
        pos_new  = {st.pos_hist[6:0], pos_now};
        neg_new  = {st.neg_hist[6:0], neg_now};
        fbit_new = {st.fbit_hist[status_pkg::SEF_WINDOW-2:0], fbit_error};
        next_st.line_evt = status_pkg::BYTE_ZERO;

        // Line bit stream monitors
        if (bit_take) begin
            next_st.pos_hist = pos_new;
            next_st.neg_hist = neg_new;
            if (pos_now || neg_now) begin
                next_st.zero_count = '0;
            end else if (st.zero_count != status_pkg::ZERO_SIXTEEN) begin
                next_st.zero_count = 5'(st.zero_count
                                        + status_pkg::ZERO_STEP);
            end
            next_st.line_evt[status_pkg::ZERO8_BIT] = !pos_now && !neg_now
                && (st.zero_count == status_pkg::ZERO_EIGHT
                                     - status_pkg::ZERO_STEP);
            next_st.line_evt[status_pkg::ZERO16_BIT] = !pos_now && !neg_now
                && (st.zero_count == status_pkg::ZERO_SIXTEEN
                                     - status_pkg::ZERO_STEP);
            next_st.line_evt[status_pkg::B8ZS_BIT] =
                (pos_new == status_pkg::B8ZS_POS_A
                 && neg_new == status_pkg::B8ZS_NEG_A)
                || (pos_new == status_pkg::B8ZS_NEG_A
                    && neg_new == status_pkg::B8ZS_POS_A);
        end

        // Framing bit error monitors
        if (fbit_strobe) begin
            next_st.fbit_hist = fbit_new;
            next_st.line_evt[status_pkg::FERR_BIT] = fbit_error;
            next_st.line_evt[status_pkg::SEF_BIT] =
                ($countones(fbit_new) >= status_pkg::SEF_LIMIT);
        end

        // Frame alignment compare on each resync after the first
        if (resync_done) begin
            next_st.line_evt[status_pkg::ALIGN_BIT] = st.offset_known
                && (frame_offset != st.last_offset);
            next_st.last_offset  = frame_offset;
            next_st.offset_known = 1'b1;
        end

        next_st.line_evt[status_pkg::ESF_BIT] = rx_estore_full;
        next_st.line_evt[status_pkg::ESE_BIT] = rx_estore_empty;

        // Mask register writes
        if (wr_en) begin
            case (addr)
                status_pkg::MASK_ONE_ADDR: next_st.irq_mask_one = wr_data;
                status_pkg::MASK_TWO_ADDR: next_st.irq_mask_two = wr_data;
                status_pkg::HDLC_MASK_ADDR: next_st.hdlc_irq_mask = wr_data;
                default: ;
            endcase
        end

        // Read data mux
        case (addr)
            status_pkg::MASK_ONE_ADDR: rd_mux = st.irq_mask_one;
            status_pkg::MASK_TWO_ADDR: rd_mux = st.irq_mask_two;
            status_pkg::HDLC_MASK_ADDR: rd_mux = st.hdlc_irq_mask;
            default: begin
                rd_mux = status_pkg::BYTE_ZERO;
                for (int i = 0; i < status_pkg::NUM_FLAG; i++) begin
                    if (addr == status_pkg::FLAG_ADDR[i]) begin
                        rd_mux = flags_all[i];
                    end
                end
            end
        endcase
        if (rd_en) begin
            next_st.rd_data = rd_mux;
        end

        // Mask bit one lets the source through
        unmasked = (pend_all[status_pkg::STAT_ONE_IDX] & st.irq_mask_one)
                 | (pend_all[status_pkg::STAT_TWO_IDX] & st.irq_mask_two)
                 | (pend_all[status_pkg::HDLC_IDX] & st.hdlc_irq_mask);
        next_st.int_n = ~|unmasked;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st       <= '0;
            st.int_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign int_n   = st.int_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seven_zeros;
        bit_take && !pos_now && !neg_now
            && st.zero_count == status_pkg::ZERO_EIGHT
                                - status_pkg::ZERO_STEP;
    endsequence

    sequence eight_latched;
        st.line_evt[status_pkg::ZERO8_BIT] ##1
            pend_all[status_pkg::INFO_ONE_IDX][status_pkg::ZERO8_BIT];
    endsequence

    irq_assert_a: assert property (
        (unmasked != 8'h00) |=> !int_n)
        else $error("pending unmasked source left interrupt high");

    irq_release_a: assert property (
        (unmasked == 8'h00) |=> int_n)
        else $error("interrupt low with nothing pending");

    mask_gate_a: assert property (
        (pend_all[status_pkg::STAT_TWO_IDX] != 8'h00
         && st.irq_mask_two == 8'h00
         && (pend_all[status_pkg::STAT_ONE_IDX] & st.irq_mask_one) == 8'h00
         && (pend_all[status_pkg::HDLC_IDX] & st.hdlc_irq_mask) == 8'h00)
        |=> int_n)
        else $error("masked source reached interrupt");

    zero_eight_a: assert property (
        seven_zeros |=> eight_latched)
        else $error("eight zero run not flagged");

    zero_sixteen_a: assert property (
        (bit_take && !pos_now && !neg_now
         && st.zero_count == status_pkg::ZERO_SIXTEEN
                             - status_pkg::ZERO_STEP)
        |=> st.line_evt[status_pkg::ZERO16_BIT])
        else $error("sixteen zero run not flagged");

    sef_window_a: assert property (
        (fbit_strobe && $countones(fbit_new) >= status_pkg::SEF_LIMIT)
        |=> st.line_evt[status_pkg::SEF_BIT])
        else $error("severe framing error missed");

    b8zs_word_a: assert property (
        (bit_take && pos_new == status_pkg::B8ZS_POS_A
         && neg_new == status_pkg::B8ZS_NEG_A)
        |=> st.line_evt[status_pkg::B8ZS_BIT])
        else $error("code word not detected");

    align_change_a: assert property (
        (resync_done && st.offset_known && frame_offset != st.last_offset)
        |=> st.line_evt[status_pkg::ALIGN_BIT])
        else $error("alignment change missed");
endmodule

// file: logic/status_pkg.sv
package status_pkg;
    localparam int NUM_FLAG       = 6;
    localparam int STAT_ONE_IDX   = 0;
    localparam int STAT_TWO_IDX   = 1;
    localparam int INFO_ONE_IDX   = 2;
    localparam int INFO_TWO_IDX   = 3;
    localparam int INFO_THREE_IDX = 4;
    localparam int HDLC_IDX       = 5;

    localparam logic [7:0] STAT_ONE_ADDR   = 8'h20;
    localparam logic [7:0] STAT_TWO_ADDR   = 8'h21;
    localparam logic [7:0] INFO_ONE_ADDR   = 8'h22;
    localparam logic [7:0] INFO_TWO_ADDR   = 8'h31;
    localparam logic [7:0] INFO_THREE_ADDR = 8'h10;
    localparam logic [7:0] HDLC_ADDR       = 8'h40;
    localparam logic [7:0] HDLC_MASK_ADDR  = 8'h41;
    localparam logic [7:0] MASK_ONE_ADDR   = 8'h7f;
    localparam logic [7:0] MASK_TWO_ADDR   = 8'h6f;

    localparam logic [NUM_FLAG-1:0][7:0] FLAG_ADDR = {
        HDLC_ADDR, INFO_THREE_ADDR, INFO_TWO_ADDR, INFO_ONE_ADDR,
        STAT_TWO_ADDR, STAT_ONE_ADDR};

    // Alarm bits of the first status register: blue, yellow, carrier, sync
    localparam logic [7:0] STAT_ONE_ALARMS = 8'h0f;
    localparam logic [7:0] NO_ALARM_BITS  = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    // First receive information register bit positions
    localparam int ALIGN_BIT = 7;
    localparam int ZERO8_BIT = 6;
    localparam int ZERO16_BIT = 5;
    localparam int ESF_BIT   = 4;
    localparam int ESE_BIT   = 3;
    localparam int SEF_BIT   = 2;
    localparam int B8ZS_BIT  = 1;
    localparam int FERR_BIT  = 0;

    // Synchroniser lanes
    localparam int RX_STB = 2;
    localparam int RX_POS = 1;
    localparam int RX_NEG = 0;

    localparam logic [4:0] ZERO_EIGHT   = 5'h08;
    localparam logic [4:0] ZERO_SIXTEEN = 5'h10;
    localparam logic [4:0] ZERO_STEP    = 5'h01;
    localparam int         SEF_WINDOW   = 6;
    localparam int         SEF_LIMIT    = 2;

    // Code word history, newest bit in the lsb: 000+-0-+ and 000-+0+-
    localparam logic [7:0] B8ZS_POS_A = 8'h11;
    localparam logic [7:0] B8ZS_NEG_A = 8'h0a;
endpackage

// file: logic/flag_bus_if.sv
`timescale 1ns/1ps
interface flag_bus_if;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] src;
    logic [7:0] flags;
    logic [7:0] pend;
    modport ctrl (output wr, rd, wdata, src, input flags, pend);
    modport regs (input wr, rd, wdata, src, output flags, pend);
endinterface

// file: logic/flag_reg.sv
`timescale 1ns/1ps
module flag_reg #(
    parameter logic [7:0] alarm_bits = 8'h00
) (
    input wire logic  clk,
    input wire logic  srst,
    flag_bus_if.regs  bus
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] shown;
        logic [7:0] armed;
        logic [7:0] alarm_pend;
        logic [7:0] alarm_prev;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;
    logic [7:0]  edge_hit;
    logic [7:0]  clr_latch;
    logic [7:0]  clr_pend;

    always_comb begin
        next_st   = st;
        edge_hit  = (bus.src ^ st.alarm_prev) & alarm_bits;
        clr_latch = bus.rd ? (st.armed & st.shown) : status_pkg::BYTE_ZERO;
        clr_pend  = bus.rd ? st.armed : status_pkg::BYTE_ZERO;
        // Set beats a same-cycle clear; alarm levels re-set while present
        next_st.latch = (st.latch & ~clr_latch) | bus.src;
        next_st.alarm_pend = (st.alarm_pend & ~clr_pend) | edge_hit;
        next_st.alarm_prev = bus.src & alarm_bits;
        if (bus.wr) begin
            // Refresh selected bits, hold the others
            next_st.shown = (bus.wdata & (st.latch | bus.src))
                          | (~bus.wdata & st.shown);
            next_st.armed = bus.wdata;
        end else if (bus.rd) begin
            next_st.armed = status_pkg::BYTE_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.flags = st.shown;
    // Events pend while latched, alarms pend from a transition until read
    assign bus.pend  = (st.latch & ~alarm_bits) | st.alarm_pend;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence mask_then_read;
        bus.wr ##1 (bus.rd && !bus.wr);
    endsequence

    set_wins_a: assert property (
        (bus.src != 8'h00) |=>
            ((st.latch & $past(bus.src)) == $past(bus.src)))
        else $error("flag set lost");

    mask_hold_a: assert property (
        bus.wr |=> (((st.shown ^ $past(st.shown))
                     & ~$past(bus.wdata)) == 8'h00))
        else $error("unmasked bit changed on write");

    read_clear_a: assert property (
        mask_then_read |=>
            ((st.latch & $past(st.shown) & $past(bus.wdata, 2)
              & ~$past(bus.src)) == 8'h00))
        else $error("read did not clear selected bit");

    alarm_edge_a: assert property (
        (((bus.src ^ st.alarm_prev) & alarm_bits) != 8'h00) |=>
            ((bus.pend & $past((bus.src ^ st.alarm_prev) & alarm_bits))
             != 8'h00))
        else $error("alarm transition raised no pending source");

    alarm_release_a: assert property (
        (bus.rd && st.armed != 8'h00 && !bus.wr
         && ((bus.src ^ st.alarm_prev) & alarm_bits) == 8'h00) |=>
            ((st.alarm_pend & $past(st.armed)) == 8'h00))
        else $error("alarm pending not released by read");

    sticky_hold_a: assert property (
        (!bus.rd && st.latch != 8'h00) |=>
            ((st.latch & $past(st.latch)) == $past(st.latch)))
        else $error("latched bit dropped without read");
endmodule

// file: testbench/mcu_model.sv
`timescale 1ns/1ps
module mcu_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] wr_data
);
    initial begin
        addr    = 8'h00;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        wr_data = 8'h00;
    end

    // Single register write
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr    = a;
        wr_data = d;
        wr_en   = 1'b1;
        @(negedge clk);
        wr_en   = 1'b0;
    endtask

    // Mask write, read, masked write-back
    task automatic poll(input logic [7:0] a, input logic [7:0] m,
                        output logic [7:0] v);
        put(a, m);
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        v     = rd_data;
        put(a, v & m);
    endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk = 1'b0, srst = 1'b1;
    logic [7:0] addr, wr_data, rd_data, v;
    logic       wr_en, rd_en, int_n;
    logic       rx_pos_in = 1'b0, rx_neg_in = 1'b0, rx_bit_strobe = 1'b0;
    logic       resync_done = 1'b0, rx_estore_full = 1'b0;
    logic       rx_estore_empty = 1'b0, fbit_strobe = 1'b0;
    logic       fbit_error = 1'b0;
    logic [7:0] frame_offset = 8'h00;
    logic [7:0] stat_one_src = 8'h00, stat_two_src = 8'h00;
    logic [7:0] e, k, m;
    int         failures = 0, compares = 0, len;
    integer     seed = 4;
    int         lens[7] = '{7, 8, 15, 16, 0, 0, 0};

    always #25 clk = ~clk;

    mcu_model mcu (.clk(clk), .rd_data(rd_data), .addr(addr),
                   .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data));

    status_irq_top DUT (
        .clk(clk), .srst(srst), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
        .int_n(int_n), .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in),
        .rx_bit_strobe(rx_bit_strobe), .resync_done(resync_done),
        .frame_offset(frame_offset), .rx_estore_full(rx_estore_full),
        .rx_estore_empty(rx_estore_empty), .fbit_strobe(fbit_strobe),
        .fbit_error(fbit_error), .stat_one_src(stat_one_src),
        .stat_two_src(stat_two_src), .info_two_src(8'h00),
        .info_three_src(8'h00), .hdlc_stat_src(8'h00));

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t byte got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t int_n got %b want %b", $time, got, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s ended", name);
    endtask

    task automatic wait3();
        repeat (3) @(negedge clk);
    endtask

    // Hold a source byte for one clock
    task automatic pulse_sr(input logic two, input logic [7:0] b);
        @(negedge clk);
        if (two) stat_two_src = b; else stat_one_src = b;
        @(negedge clk);
        if (two) stat_two_src = 8'h00; else stat_one_src = 8'h00;
    endtask

    task automatic send_bit(input logic p, input logic n);
        @(negedge clk);
        rx_pos_in = p;
        rx_neg_in = n;
        @(negedge clk);
        rx_bit_strobe = 1'b1;
        repeat (2) @(negedge clk);
        rx_bit_strobe = 1'b0;
        @(negedge clk);
    endtask

    task automatic fbit(input logic err);
        @(negedge clk);
        fbit_strobe = 1'b1;
        fbit_error  = err;
        @(negedge clk);
        fbit_strobe = 1'b0;
        fbit_error  = 1'b0;
    endtask

    task automatic resync(input logic [7:0] off);
        @(negedge clk);
        resync_done  = 1'b1;
        frame_offset = off;
        @(negedge clk);
        resync_done  = 1'b0;
    endtask

    function automatic logic [7:0] zero_flags(input int n);
        return {1'b0, n >= 8, n >= 16, 5'h00};
    endfunction

    initial begin
        #(50 * 20000);
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check8(rd_data, 8'h00);
        check1(int_n, 1'b1);
        done("reset");

        mcu.put(status_pkg::MASK_ONE_ADDR, 8'hff);
        pulse_sr(1'b0, 8'h10);
        wait3();
        check1(int_n, 1'b0);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h10, v);
        check8(v, 8'h10);
        check1(int_n, 1'b1);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h10, v);
        check8(v, 8'h00);
        done("event irq");

        @(negedge clk);
        stat_one_src = 8'h08;
        wait3();
        check1(int_n, 1'b0);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h08, v);
        check8(v, 8'h08);
        check1(int_n, 1'b1);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h08, v);
        check8(v, 8'h08);
        check1(int_n, 1'b1);
        stat_one_src = 8'h00;
        wait3();
        check1(int_n, 1'b0);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h08, v);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h08, v);
        check8(v, 8'h00);
        check1(int_n, 1'b1);
        done("alarm irq");

        mcu.put(status_pkg::MASK_ONE_ADDR, 8'h00);
        pulse_sr(1'b0, 8'h20);
        wait3();
        check1(int_n, 1'b1);
        mcu.poll(status_pkg::STAT_ONE_ADDR, 8'h20, v);
        check8(v, 8'h20);
        done("masked");

        for (int i = 0; i < 4; i++) begin
            k = 8'($random(seed));
            e = 8'($random(seed)) | 8'h01;
            m = 8'($random(seed));
            mcu.put(status_pkg::MASK_TWO_ADDR, k);
            pulse_sr(1'b1, e);
            wait3();
            check1(int_n, ~|(e & k));
            mcu.poll(status_pkg::STAT_TWO_ADDR, m, v);
            check8(v & m, e & m);
            mcu.poll(status_pkg::STAT_TWO_ADDR, 8'hff, v);
            check8(v, e & ~m);
            check1(int_n, 1'b1);
        end
        done("mask byte");

        for (int i = 4; i < 7; i++)
            lens[i] = 1 + ($unsigned($random(seed)) % 24);
        foreach (lens[i]) begin
            len = lens[i];
            send_bit(1'b1, 1'b0);
            repeat (len) send_bit(1'b0, 1'b0);
            send_bit(1'b0, 1'b1);
            mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h60, v);
            check8(v & 8'h60, zero_flags(len));
        end
        done("zero runs");

        // 000+-0-+ after a positive mark
        send_bit(1'b1, 1'b0);
        foreach (lens[i]) if (i < 3) send_bit(1'b0, 1'b0);
        send_bit(1'b1, 1'b0);
        send_bit(1'b0, 1'b1);
        send_bit(1'b0, 1'b0);
        send_bit(1'b0, 1'b1);
        send_bit(1'b1, 1'b0);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h02, v);
        check8(v & 8'h02, 8'h02);
        done("code word");

        repeat (6) fbit(1'b0);
        fbit(1'b1);
        repeat (5) fbit(1'b0);
        fbit(1'b1);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h05, v);
        check8(v & 8'h05, 8'h01);
        fbit(1'b1);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h05, v);
        check8(v & 8'h05, 8'h05);
        done("framing");

        @(negedge clk);
        rx_estore_full = 1'b1;
        @(negedge clk);
        rx_estore_full  = 1'b0;
        rx_estore_empty = 1'b1;
        @(negedge clk);
        rx_estore_empty = 1'b0;
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h18, v);
        check8(v & 8'h18, 8'h18);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h18, v);
        check8(v & 8'h18, 8'h00);
        done("slips");

        resync(8'h03);
        resync(8'h03);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h80, v);
        check8(v & 8'h80, 8'h00);
        resync(8'h05);
        mcu.poll(status_pkg::INFO_ONE_ADDR, 8'h80, v);
        check8(v & 8'h80, 8'h80);
        done("alignment");

        mcu.poll(8'h05, 8'hff, v);
        check8(v, 8'h00);
        done("unmapped");
        tally_and_finish();
    end
endmodule
